// file: mdio_slave_defs.svh
// Timing counts, frame field positions and address map constants for the management slave.
// Assumes it is included by bare name; it needs none of the mdio_slave_pkg types, and the pin synchroniser includes it without them.
//
// Summary of operation
// - Management clock up to 10 MHz; frames decode correctly at any rate to there.
// - Frame: 32 ones, 01, opcode, PHY address, register address, turnaround, 16 data, idle.
// - Opcode 10 with PHY address bits [2:1] both one is an extended read.
// - Opcode 01 with PHY address bits [2:1] one is extended write; master sends turnaround 10.
// - Extended address is {PHY bits 4:3, PHY bit 0, five register address bits}.
// - On reads master releases in first turnaround bit; slave drives 0 then data.
// - Extended reads return the byte low and zeros in data bits [15:8].
// - Extended writes store the low byte only; bits [15:8] are ignored.
// - Standard mode reaches only PHY registers 0 to 5, 1d and 1f, nothing else.
// - Standard registers are 16 bits; every port has its own eight.
// - Extended access covers configuration addresses 0x00 to 0xFF.
// - Extended frames share all timing and field rules with standard frames.
`ifndef MDIO_SLAVE_DEFS_SVH
`define MDIO_SLAVE_DEFS_SVH

`define SYS_CLK_HZ        20000000
`define MDC_MAX_HZ        10000000
`define PREAMBLE_ONES     6'h20
`define OP_READ           2'h2
`define OP_WRITE          2'h1
`define EXT_SEL_BITS      2'h3
`define PORT_COUNT        4
`define PHY_REG_LAST_STD  5'h05
`define PHY_REG_CUSTOM_A  5'h1D
`define PHY_REG_CUSTOM_B  5'h1F
`define PHY_BASE_DEFAULT  5'h01
`define DATA_BITS         5'h10

`endif

// file: mdio_slave_pkg.sv
// Types shared by the management slave modules.
// Assumes nothing of its surroundings.
package mdio_slave_pkg;

  typedef enum logic [2:0] {
    ST_PREAMBLE,
    ST_START,
    ST_HEADER,
    ST_TURN,
    ST_DATA,
    ST_IDLE
  } frame_state_t;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_STANDARD,
    ACC_EXTENDED
  } access_kind_t;

endpackage : mdio_slave_pkg

// file: mdio_pin_sync.sv
// Two-flop synchroniser and rising- and falling-edge finder for the management clock and data pins.
// Assumes sys_clk runs at least twice as fast as the management clock.
`timescale 1ns/1ps
`include "mdio_slave_defs.svh"

module mdio_pin_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdc_rise,
  output logic      mdc_fall,
  output logic      mdio_sync
);

  logic [1:0] mdc_meta_reg;
  logic [1:0] mdio_meta_reg;
  logic       mdc_last_reg;

  // The first flops feed only the second ones; edges are found on the settled copy.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mdc_meta_reg  <= 2'h0;
      mdio_meta_reg <= 2'h3;
      mdc_last_reg  <= 1'b0;
    end else begin
      mdc_meta_reg  <= {mdc_meta_reg[0], mdc};
      mdio_meta_reg <= {mdio_meta_reg[0], mdio_in};
      mdc_last_reg  <= mdc_meta_reg[1];
    end
  end

  // A 10 MHz clock gives one sys_clk high and one low sample, enough for both edges.
  assign mdc_rise  = mdc_meta_reg[1] & ~mdc_last_reg;
  assign mdc_fall  = ~mdc_meta_reg[1] & mdc_last_reg;
  assign mdio_sync = mdio_meta_reg[1];

endmodule : mdio_pin_sync

// file: mdio_management_slave.sv
// Management frame slave: standard per-port PHY registers and extended 8-bit config access.
// Assumes register storage lives outside; reads are answered combinationally from it
// within the half management clock period between the read request and the fall in the first turnaround bit.
`timescale 1ns/1ps
`include "mdio_slave_defs.svh"

module mdio_management_slave
  import mdio_slave_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [4:0]  phy_base_addr,
  output logic             phy_rd_req,
  output logic             phy_wr_req,
  output logic [1:0]       phy_port,
  output logic [4:0]       phy_reg,
  output logic [15:0]      phy_wr_data,
  input  wire logic [15:0] phy_rd_data,
  output logic             cfg_rd_req,
  output logic             cfg_wr_req,
  output logic [7:0]       cfg_addr,
  output logic [7:0]       cfg_wr_data,
  input  wire logic [7:0]  cfg_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling.

  logic mdc_rise;
  logic mdc_fall;
  logic mdio_bit;

  mdio_pin_sync u_sync (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .mdc       (mdc),
    .mdio_in   (mdio_in),
    .mdc_rise  (mdc_rise),
    .mdc_fall  (mdc_fall),
    .mdio_sync (mdio_bit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame state.

  frame_state_t state_reg;
  frame_state_t state_next;
  logic [5:0]   count_reg;
  logic [5:0]   count_next;
  logic [11:0]  header_reg;
  logic [15:0]  shift_reg;
  access_kind_t kind_reg;
  logic [15:0]  rd_word_reg;
  logic         reading_reg;

  // Header holds opcode[11:10], PHY address field [9:5], register address field [4:0].
  // The fields read the header with the final address bit still on the line, so the
  // frame kind is known at the very rise that ends the header.
  wire [11:0] header_full    = {header_reg[10:0], mdio_bit};
  wire [1:0]  opcode         = header_reg[11:10];
  wire [1:0]  hdr_op         = header_full[11:10];
  wire [4:0]  phy_addr_field = header_full[9:5];
  wire [4:0]  reg_addr_field = header_full[4:0];

  function automatic logic std_reg_ok(input logic [4:0] r);
    std_reg_ok = (r <= `PHY_REG_LAST_STD) || (r == `PHY_REG_CUSTOM_A)
               || (r == `PHY_REG_CUSTOM_B);
  endfunction : std_reg_ok

  wire       op_valid   = (hdr_op == `OP_READ) || (hdr_op == `OP_WRITE);
  wire       ext_sel    = op_valid && (phy_addr_field[2:1] == `EXT_SEL_BITS);
  wire [4:0] port_off   = phy_addr_field - phy_base_addr;
  wire       port_hit   = (port_off < 5'(`PORT_COUNT));
  wire       std_hit    = op_valid && port_hit && std_reg_ok(reg_addr_field);
  wire [7:0] ext_addr   = {phy_addr_field[4:3], phy_addr_field[0], reg_addr_field};
  wire       header_end = (state_reg == ST_HEADER) && (count_reg == 6'h0B);
  wire       is_read    = (opcode == `OP_READ);

  access_kind_t hdr_kind;
  assign hdr_kind = ext_sel ? ACC_EXTENDED : (std_hit ? ACC_STANDARD : ACC_NONE);

  // The preamble needs 32 ones; a zero after that many is the first start bit.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg + 6'h01;
    unique case (state_reg)
      ST_PREAMBLE: begin
        if (!mdio_bit) begin
          count_next = 6'h00;
          if (count_reg >= `PREAMBLE_ONES) begin
            state_next = ST_START;
          end
        end else if (count_reg >= `PREAMBLE_ONES) begin
          count_next = `PREAMBLE_ONES;
        end
      end
      ST_START: begin
        count_next = 6'h00;
        state_next = mdio_bit ? ST_HEADER : ST_PREAMBLE;
      end
      ST_HEADER: begin
        if (count_reg == 6'h0B) begin
          count_next = 6'h00;
          state_next = (hdr_kind == ACC_NONE) ? ST_IDLE : ST_TURN;
        end
      end
      ST_TURN: begin
        if (count_reg == 6'h01) begin
          count_next = 6'h00;
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (count_reg == 6'(`DATA_BITS) - 6'h01) begin
          count_next = 6'h00;
          state_next = ST_PREAMBLE;
        end
      end
      ST_IDLE: begin
        // An ignored frame keeps the line released for its turnaround and data.
        if (count_reg == 6'h11) begin
          count_next = 6'h00;
          state_next = ST_PREAMBLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_PREAMBLE;
      count_reg <= 6'h00;
    end else if (mdc_rise) begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      header_reg <= 12'h000;
      shift_reg  <= 16'h0000;
      kind_reg   <= ACC_NONE;
    end else if (mdc_rise) begin
      if (state_reg == ST_HEADER) begin
        header_reg <= header_full;
      end
      if (header_end) begin
        kind_reg <= hdr_kind;
      end
      if (state_reg == ST_DATA) begin
        shift_reg <= {shift_reg[14:0], mdio_bit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register side requests and captured data.

  wire frame_done = mdc_rise && (state_reg == ST_DATA) && (count_reg == 6'h0F);
  wire [15:0] wr_word = {shift_reg[14:0], mdio_bit};
  wire start_read = mdc_rise && (state_reg == ST_TURN) && (count_reg == 6'h00) && is_read;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phy_rd_req  <= 1'b0;
      phy_wr_req  <= 1'b0;
      cfg_rd_req  <= 1'b0;
      cfg_wr_req  <= 1'b0;
      phy_port    <= 2'h0;
      phy_reg     <= 5'h00;
      phy_wr_data <= 16'h0000;
      cfg_addr    <= 8'h00;
      cfg_wr_data <= 8'h00;
    end else begin
      phy_rd_req <= start_read && (kind_reg == ACC_STANDARD);
      cfg_rd_req <= start_read && (kind_reg == ACC_EXTENDED);
      phy_wr_req <= frame_done && !is_read && (kind_reg == ACC_STANDARD);
      cfg_wr_req <= frame_done && !is_read && (kind_reg == ACC_EXTENDED);
      if (header_end && mdc_rise) begin
        phy_port <= port_off[1:0];
        phy_reg  <= reg_addr_field;
        cfg_addr <= ext_addr;
      end
      if (frame_done) begin
        phy_wr_data <= wr_word;
        cfg_wr_data <= wr_word[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read turnaround and data drive.

  // Drive changes on the falling edge so the master samples a settled bit on the rise.
  wire in_turn_one = (state_reg == ST_TURN) && (count_reg == 6'h01);
  wire drive_win   = reading_reg && ((state_reg == ST_DATA) || in_turn_one);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reading_reg <= 1'b0;
      rd_word_reg <= 16'h0000;
      mdio_out    <= 1'b1;
      mdio_oe     <= 1'b0;
    end else begin
      if (start_read) begin
        reading_reg <= 1'b1;
      end else if (state_reg == ST_PREAMBLE || state_reg == ST_IDLE) begin
        reading_reg <= 1'b0;
      end
      if (mdc_fall) begin
        if (in_turn_one && reading_reg) begin
          mdio_out    <= 1'b0;
          mdio_oe     <= 1'b1;
          rd_word_reg <= (kind_reg == ACC_EXTENDED) ? {8'h00, cfg_rd_data} : phy_rd_data;
        end else if (drive_win && state_reg == ST_DATA) begin
          mdio_out    <= rd_word_reg[15];
          rd_word_reg <= {rd_word_reg[14:0], 1'b0};
        end else begin
          mdio_out <= 1'b1;
          mdio_oe  <= 1'b0;
        end
      end
    end
  end

endmodule : mdio_management_slave

// file: mdio_slave_chk.sv
// Checker for the management slave; sees only the top module ports.
// Assumes a 400 ns management clock beside the 50 ns system clock.
`timescale 1ns/1ps
module mdio_slave_chk (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic       phy_rd_req,
  input wire logic       phy_wr_req,
  input wire logic [4:0] phy_reg,
  input wire logic       cfg_rd_req,
  input wire logic       cfg_wr_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] oe_cnt;
  logic [7:0] req_age;
  logic       ext_rd;
  wire        rd_req  = phy_rd_req | cfg_rd_req;
  wire        any_req = rd_req | phy_wr_req | cfg_wr_req;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      oe_cnt  <= 8'h00;
      req_age <= 8'hFF;
      ext_rd  <= 1'b0;
    end else begin
      oe_cnt  <= mdio_oe ? oe_cnt + 8'h01 : 8'h00;
      req_age <= rd_req ? 8'h00 : (req_age == 8'hFF ? req_age : req_age + 8'h01);
      ext_rd  <= cfg_rd_req | (ext_rd & ~phy_rd_req);
    end
  end
  ////////////////////////////////////////
  property p_req_pulse; any_req |=> !any_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("Request held too long.");
  property p_rd_oe; rd_req |-> ##[1:8] mdio_oe; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("Read not answered.");
  property p_oe_cause; $rose(mdio_oe) |-> req_age < 8'h0A; endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("Line driven without a read.");
  property p_ta_zero; $rose(mdio_oe) |-> !mdio_out; endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("Turnaround bit not zero.");
  property p_oe_len; $fell(mdio_oe) |-> (oe_cnt > 8'h84 && oe_cnt < 8'h8C); endproperty
  a_oe_len: assert property (p_oe_len) else $error("Drive length wrong.");
  property p_ext_hi; (ext_rd && mdio_oe && oe_cnt < 8'h40) |-> !mdio_out; endproperty
  a_ext_hi: assert property (p_ext_hi) else $error("Upper byte not zero.");
  property p_quiet_wr; mdio_oe |-> !(cfg_wr_req || phy_wr_req); endproperty
  a_quiet_wr: assert property (p_quiet_wr) else $error("Write during read.");
  property p_std_reg;
    (phy_rd_req || phy_wr_req) |-> (phy_reg <= 5'h05 || phy_reg == 5'h1D || phy_reg == 5'h1F);
  endproperty
  a_std_reg: assert property (p_std_reg) else $error("Standard register out of map.");
  c_ext_rd: cover property (cfg_rd_req);
  c_ext_wr: cover property (cfg_wr_req);
  c_std_rd: cover property (phy_rd_req);
endmodule : mdio_slave_chk

bind mdio_management_slave mdio_slave_chk u_chk (.sys_clk(sys_clk), .reset(reset),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_rd_req(phy_rd_req), .phy_wr_req(phy_wr_req),
  .phy_reg(phy_reg), .cfg_rd_req(cfg_rd_req), .cfg_wr_req(cfg_wr_req));

// file: mdio_master_model.sv
// External management master: makes the link clock and drives the data line.
// Assumes the bench resolves the line from both enables and a pull-up.
`timescale 1ns/1ps
module mdio_master_model (
  output logic      mdc,
  output logic      drv_oe,
  output logic      drv_out,
  input  wire logic line
);
  initial begin
    mdc     = 1'b0;
    drv_oe  = 1'b0;
    drv_out = 1'b1;
  end
  ////////////////////////////////////////
  // The clock stays low between frames; a 400 ns period keeps well under the limit.
  task automatic bit_cycle(input logic oe, input logic val, output logic got);
    drv_oe  = oe;
    drv_out = val;
    #200 mdc = 1'b1;
    got = line;
    #200 mdc = 1'b0;
  endtask : bit_cycle
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [16:0] rd);
    logic [47:0] hdr;
    logic        got;
    hdr = {32'hFFFFFFFF, 2'h1, op, phy, rg, 2'h2};
    rd  = 17'h00000;
    #7;
    for (int i = 47; i >= 0; i--) begin
      bit_cycle(!(op == 2'h2 && i < 2), hdr[i], got);
      if (i == 0) rd[16] = got;
    end
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(op != 2'h2, wd[i], got);
      rd[i] = got;
    end
    drv_oe = 1'b0;
    #400;
  endtask : frame
endmodule : mdio_master_model

// file: mdio_management_slave_bench.sv
// Self-checking bench for the management slave with a master model on the link.
// Assumes register storage answers from the request until the turnaround.
`timescale 1ns/1ps
module mdio_management_slave_bench;
  logic        sys_clk, reset, mdc, drv_oe, drv_out, mdio_out, mdio_oe;
  logic        phy_rd_req, phy_wr_req, cfg_rd_req, cfg_wr_req;
  logic [1:0]  phy_port;
  logic [4:0]  phy_base_addr, phy_reg;
  logic [15:0] phy_wr_data, phy_rd_data;
  logic [7:0]  cfg_addr, cfg_wr_data, cfg_rd_data, phy_wr_seen, cfg_wr_seen;
  logic [16:0] rd;
  int          err_count, compares;
  // A pull-up holds the line high whenever nobody drives it.
  wire         mdio_line = mdio_oe ? mdio_out : (drv_oe ? drv_out : 1'b1);
  mdio_master_model m (.mdc(mdc), .drv_oe(drv_oe), .drv_out(drv_out), .line(mdio_line));
  mdio_management_slave uut (.sys_clk(sys_clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_line),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_base_addr(phy_base_addr),
    .phy_rd_req(phy_rd_req), .phy_wr_req(phy_wr_req), .phy_port(phy_port), .phy_reg(phy_reg),
    .phy_wr_data(phy_wr_data), .phy_rd_data(phy_rd_data), .cfg_rd_req(cfg_rd_req),
    .cfg_wr_req(cfg_wr_req), .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data),
    .cfg_rd_data(cfg_rd_data));
  always #25 sys_clk = ~sys_clk;
  // Storage contents follow the address, so a wrong address shows in the data.
  always @(posedge sys_clk) begin
    phy_rd_data <= {phy_port, phy_reg, 9'h155};
    cfg_rd_data <= ~cfg_addr;
    phy_wr_seen <= phy_wr_seen + {7'h00, phy_wr_req};
    cfg_wr_seen <= cfg_wr_seen + {7'h00, cfg_wr_req};
  end
  ////////////////////////////////////////
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic ext_read;
    m.frame(2'h2, 5'h17, 5'h0A, 16'h0000, rd);
    check(rd, {9'h000, 8'h55});
    check({9'h000, cfg_addr}, 17'h000AA);
    m.frame(2'h2, 5'h1F, 5'h1F, 16'h0000, rd);
    check(rd, {9'h000, 8'h00});
    m.frame(2'h2, 5'h06, 5'h00, 16'h0000, rd);
    check(rd, {9'h000, 8'hFF});
  endtask : ext_read
  task automatic ext_write;
    m.frame(2'h1, 5'h0E, 5'h03, 16'hFF3C, rd);
    check({9'h000, cfg_addr}, 17'h00043);
    check({9'h000, cfg_wr_data}, 17'h0003C);
    check({9'h000, cfg_wr_seen}, 17'h00001);
  endtask : ext_write
  task automatic std_access;
    m.frame(2'h2, 5'h03, 5'h1D, 16'h0000, rd);
    check(rd, {1'b0, 2'h2, 5'h1D, 9'h155});
    m.frame(2'h2, 5'h04, 5'h05, 16'h0000, rd);
    check(rd, {1'b0, 2'h3, 5'h05, 9'h155});
    m.frame(2'h1, 5'h01, 5'h00, 16'h1234, rd);
    check({1'b0, phy_wr_data}, 17'h01234);
    check({15'h0000, phy_port}, 17'h00000);
    check({9'h000, phy_wr_seen}, 17'h00001);
  endtask : std_access
  task automatic refused;
    m.frame(2'h2, 5'h01, 5'h06, 16'h0000, rd);
    check(rd, 17'h1FFFF);
    m.frame(2'h2, 5'h09, 5'h00, 16'h0000, rd);
    check(rd, 17'h1FFFF);
    m.frame(2'h1, 5'h09, 5'h00, 16'hABCD, rd);
    check({1'b0, phy_wr_data}, 17'h01234);
    check({9'h000, phy_wr_seen}, 17'h00001);
    // Opcode 11 is neither read nor write; the master drives the data itself.
    m.frame(2'h3, 5'h01, 5'h00, 16'hFFFF, rd);
    check(rd, 17'h0FFFF);
    check({9'h000, phy_wr_seen}, 17'h00001);
    check({9'h000, cfg_wr_seen}, 17'h00001);
  endtask : refused
  task automatic base_move;
    @(posedge sys_clk) phy_base_addr <= 5'h08;
    m.frame(2'h2, 5'h0B, 5'h02, 16'h0000, rd);
    check(rd, {1'b0, 2'h3, 5'h02, 9'h155});
    m.frame(2'h2, 5'h01, 5'h02, 16'h0000, rd);
    check(rd, 17'h1FFFF);
  endtask : base_move
  // Reset lands while the slave drives read data; the line must be released at once.
  task automatic mid_reset;
    fork
      m.frame(2'h2, 5'h17, 5'h0A, 16'h0000, rd);
      begin
        #20000;
        @(posedge sys_clk) reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check({16'h0000, mdio_oe}, 17'h00000);
      end
    join
    m.frame(2'h2, 5'h06, 5'h00, 16'h0000, rd);
    check(rd, {9'h000, 8'hFF});
  endtask : mid_reset
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    #1000000;
    err_count++;
    results();
  end
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    phy_base_addr = 5'h01;
    phy_rd_data = 16'h0000;
    cfg_rd_data = 8'h00;
    phy_wr_seen = 8'h00;
    cfg_wr_seen = 8'h00;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    ext_read();
    ext_write();
    std_access();
    refused();
    base_move();
    mid_reset();
    results();
  end
endmodule : mdio_management_slave_bench
